//--- hdl/ismd_pkg.sv
// shared constants and types for the subtract, multiply and divide unit
package ismd_pkg;

    // =========================================================
    // bus and widths
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int IMM_W = 13;
    localparam int HTRANS_ACT_BIT = 1;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // =========================================================
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_SRC_A = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SRC_B = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_IMM = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_EXT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CMD = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h1C;

    // =========================================================
    // fields
    localparam int OP_W = 4;
    localparam int CMD_IMM_BIT = 4;
    localparam int FLG_W = 4;
    localparam int FLG_N = 3;
    localparam int FLG_Z = 2;
    localparam int FLG_V = 1;
    localparam int FLG_C = 0;
    localparam int STS_BUSY = 0;
    localparam int STS_DONE = 1;
    localparam int STS_TAG = 2;
    localparam int STS_DZERO = 3;
    localparam int STS_DOVF = 4;

    // =========================================================
    // operation codes written to the command register
    localparam logic [OP_W-1:0] OP_DIFF = 4'h0;
    localparam logic [OP_W-1:0] OP_DIFF_CC = 4'h1;
    localparam logic [OP_W-1:0] OP_BORROW = 4'h2;
    localparam logic [OP_W-1:0] OP_BORROW_CC = 4'h3;
    localparam logic [OP_W-1:0] OP_TAG_CC = 4'h4;
    localparam logic [OP_W-1:0] OP_TAG_TRAP = 4'h5;
    localparam logic [OP_W-1:0] OP_MUL_STEP = 4'h6;
    localparam logic [OP_W-1:0] OP_UPROD = 4'h7;
    localparam logic [OP_W-1:0] OP_SPROD = 4'h8;
    localparam logic [OP_W-1:0] OP_UPROD_CC = 4'h9;
    localparam logic [OP_W-1:0] OP_SPROD_CC = 4'hA;
    localparam logic [OP_W-1:0] OP_UQUOT = 4'hB;
    localparam logic [OP_W-1:0] OP_SQUOT = 4'hC;
    localparam logic [OP_W-1:0] OP_UQUOT_CC = 4'hD;
    localparam logic [OP_W-1:0] OP_SQUOT_CC = 4'hE;

    // =========================================================
    // divide saturation values and sequencing
    localparam logic [31:0] SAT_UNSIGNED = 32'hFFFFFFFF;
    localparam logic [31:0] SAT_POS = 32'h7FFFFFFF;
    localparam logic [31:0] SAT_NEG = 32'h80000000;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] DIV_LAST = 6'h3F;

    typedef enum logic [1:0] {DS_IDLE, DS_STEP, DS_END} ismd_state_t;

endpackage

//--- hdl/ismd_unit.sv
// subtract, multiply-step, multiply and divide datapath behind AHB-Lite
// Notes on behaviour
// - plain and flag subtracts write source a minus operand b to result
// - borrow subtracts also take away the stored carry flag
// - flag subtracts update flags; overflow from signs of a, b, result
// - tag fault if low two bits of either operand set or overflow
// - trapping tagged subtract on fault traps, keeps result and flags
// - trapping tagged subtract without fault writes result, flags, V=0
// - flag tagged subtract sets V to fault, always writes, never traps
// - multiply step sees source a and extension as one 64-bit pair
// - step shifts a right once, top bit filled with N xor V
// - step adds operand b when extension LSB set, flags from that sum
// - step shifts extension right, MSB from original a LSB
// - full multiply: high word to extension, low word to result
// - unsigned and signed products treat operands accordingly
// - flag multiplies: N from bit 31, Z on low word zero, V=C=0
// - divide 64-bit dividend by 32-bit operand b, quotient to result
// - signed quotient truncates toward zero
// - unsigned quotient overflow saturates to all ones
// - signed overflow saturates to largest positive or negative
// - flag divides: N from quotient bit 31, Z on zero quotient
// - flag divides set V on divide overflow and clear C
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module ismd_unit (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic trap_tag,
    output logic trap_div_zero,
    output logic op_done
);

    // =========================================================
    // state
    logic [31:0] src_a_q, src_b_q, ext_q, result_q;
    logic [ismd_pkg::IMM_W-1:0] imm_q;
    logic [ismd_pkg::FLG_W-1:0] flags_q;
    logic [ismd_pkg::OP_W:0] cmd_q;
    logic wr_pend_q;
    logic [ismd_pkg::ADDR_W-1:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q, hresp_q;
    logic trap_tag_q, trap_dz_q, dovf_q, done_q, op_done_q;
    ismd_pkg::ismd_state_t state_q;
    logic [ismd_pkg::CNT_W-1:0] cnt_q;
    logic [63:0] dvd_q;
    logic [32:0] rem_q;
    logic [31:0] dvs_q;
    logic neg_q, signed_q, div_cc_q;
    logic busy, bus_wr, launch;
    logic [ismd_pkg::OP_W-1:0] op;
    logic [31:0] opnd_b;
    // combinational engine outputs
    logic [32:0] sub_full, step_full, div_shift;
    logic [31:0] step_sh, step_add, div_val;
    logic [63:0] uprod, sprod, prod, dvd_mag;
    logic borrow_in, sub_ovf, tag_fault, step_ovf, div_ge, div_ovf;
    logic res_we, flg_we, ext_we, tag_trap, dz_trap, div_go;
    logic [31:0] res_val, ext_val;
    logic [ismd_pkg::FLG_W-1:0] flg_val;

    assign busy = state_q != ismd_pkg::DS_IDLE;
    // writes while a divide runs are dropped so operands stay stable
    assign bus_wr = wr_pend_q && !busy;
    assign launch = bus_wr && wr_addr_q == ismd_pkg::OFF_CMD;
    assign op = hwdata[ismd_pkg::OP_W-1:0];
    // the immediate choice comes with the command word itself
    assign opnd_b = hwdata[ismd_pkg::CMD_IMM_BIT]
        ? {{(32 - ismd_pkg::IMM_W){imm_q[ismd_pkg::IMM_W-1]}}, imm_q}
        : src_b_q;

    // =========================================================
    // ahb-lite address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[ismd_pkg::HTRANS_ACT_BIT] && hwrite
                && hsize == ismd_pkg::HSIZE_WORD;
            wr_addr_q <= haddr[ismd_pkg::ADDR_W-1:0];
        end
    end

    // read data is sampled in the address phase; zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= '0;
        end else if (hready && hsel && htrans[ismd_pkg::HTRANS_ACT_BIT]
                     && !hwrite) begin
            unique case (haddr[ismd_pkg::ADDR_W-1:0])
                ismd_pkg::OFF_SRC_A: hrdata_q <= src_a_q;
                ismd_pkg::OFF_SRC_B: hrdata_q <= src_b_q;
                ismd_pkg::OFF_IMM: hrdata_q <= 32'(imm_q);
                ismd_pkg::OFF_EXT: hrdata_q <= ext_q;
                ismd_pkg::OFF_FLAGS: hrdata_q <= 32'(flags_q);
                ismd_pkg::OFF_CMD: hrdata_q <= 32'(cmd_q);
                ismd_pkg::OFF_RESULT: hrdata_q <= result_q;
                ismd_pkg::OFF_STATUS: hrdata_q <= 32'({dovf_q, trap_dz_q,
                    trap_tag_q, done_q, busy});
                default: hrdata_q <= '0;
            endcase
        end
    end
    // slave is always ready and always answers okay; both from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hresp_q <= ismd_pkg::HRESP_OKAY;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q <= ismd_pkg::HRESP_OKAY;
        end
    end
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    // =========================================================
    // operand registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_a_q <= '0;
            src_b_q <= '0;
            imm_q <= '0;
            cmd_q <= '0;
        end else if (bus_wr) begin
            unique case (wr_addr_q)
                ismd_pkg::OFF_SRC_A: src_a_q <= hwdata;
                ismd_pkg::OFF_SRC_B: src_b_q <= hwdata;
                ismd_pkg::OFF_IMM: imm_q <= hwdata[ismd_pkg::IMM_W-1:0];
                ismd_pkg::OFF_CMD: cmd_q <= hwdata[ismd_pkg::OP_W:0];
                default: ;
            endcase
        end
    end

    // =========================================================
    // single-cycle engine
    always_comb begin
        borrow_in = (op == ismd_pkg::OP_BORROW
            || op == ismd_pkg::OP_BORROW_CC) && flags_q[ismd_pkg::FLG_C];
        sub_full = {1'b0, src_a_q} - {1'b0, opnd_b} - {32'h0, borrow_in};
        sub_ovf = (src_a_q[31] != opnd_b[31])
            && (sub_full[31] != src_a_q[31]);
        tag_fault = (|src_a_q[1:0]) || (|opnd_b[1:0]) || sub_ovf;
        // pair a:ext shifts right; N^V restores the partial sign
        step_sh = {flags_q[ismd_pkg::FLG_N] ^ flags_q[ismd_pkg::FLG_V],
            src_a_q[31:1]};
        step_add = ext_q[0] ? opnd_b : 32'h0;
        step_full = {1'b0, step_sh} + {1'b0, step_add};
        step_ovf = (step_sh[31] == step_add[31])
            && (step_full[31] != step_sh[31]);
        uprod = {32'h0, src_a_q} * {32'h0, opnd_b};
        sprod = 64'($signed({{32{src_a_q[31]}}, src_a_q})
            * $signed({{32{opnd_b[31]}}, opnd_b}));
        prod = (op == ismd_pkg::OP_SPROD || op == ismd_pkg::OP_SPROD_CC)
            ? sprod : uprod;
        dvd_mag = {ext_q, src_a_q};
        res_we = 1'b0;
        flg_we = 1'b0;
        ext_we = 1'b0;
        tag_trap = 1'b0;
        dz_trap = 1'b0;
        div_go = 1'b0;
        res_val = sub_full[31:0];
        ext_val = prod[63:32];
        flg_val = {sub_full[31], sub_full[31:0] == 32'h0, sub_ovf,
            sub_full[32]};
        unique case (op)
            ismd_pkg::OP_DIFF, ismd_pkg::OP_BORROW: res_we = 1'b1;
            ismd_pkg::OP_DIFF_CC, ismd_pkg::OP_BORROW_CC: begin
                res_we = 1'b1;
                flg_we = 1'b1;
            end
            ismd_pkg::OP_TAG_CC: begin
                res_we = 1'b1;
                flg_we = 1'b1;
                flg_val[ismd_pkg::FLG_V] = tag_fault;
            end
            ismd_pkg::OP_TAG_TRAP: begin
                tag_trap = tag_fault;
                res_we = !tag_fault;
                flg_we = !tag_fault;
                flg_val[ismd_pkg::FLG_V] = 1'b0;
            end
            ismd_pkg::OP_MUL_STEP: begin
                res_we = 1'b1;
                flg_we = 1'b1;
                ext_we = 1'b1;
                res_val = step_full[31:0];
                flg_val = {step_full[31], step_full[31:0] == 32'h0,
                    step_ovf, step_full[32]};
                ext_val = {src_a_q[0], ext_q[31:1]};
            end
            ismd_pkg::OP_UPROD, ismd_pkg::OP_SPROD,
            ismd_pkg::OP_UPROD_CC, ismd_pkg::OP_SPROD_CC: begin
                res_we = 1'b1;
                ext_we = 1'b1;
                res_val = prod[31:0];
                flg_we = op == ismd_pkg::OP_UPROD_CC
                    || op == ismd_pkg::OP_SPROD_CC;
                flg_val = {prod[31], prod[31:0] == 32'h0, 1'b0, 1'b0};
            end
            ismd_pkg::OP_UQUOT, ismd_pkg::OP_SQUOT,
            ismd_pkg::OP_UQUOT_CC, ismd_pkg::OP_SQUOT_CC: begin
                dz_trap = opnd_b == 32'h0;
                div_go = opnd_b != 32'h0;
            end
            default: ;
        endcase
        if (op == ismd_pkg::OP_SQUOT || op == ismd_pkg::OP_SQUOT_CC) begin
            // divide magnitudes; truncation then matches toward-zero
            if (dvd_mag[63]) begin
                dvd_mag = 64'h0 - dvd_mag;
            end
        end
    end

    // =========================================================
    // divide sequencer: one quotient bit per cycle, 64 steps
    always_comb begin
        div_shift = {rem_q[31:0], dvd_q[63]};
        div_ge = div_shift >= {1'b0, dvs_q};
        if (!signed_q) begin
            div_ovf = |dvd_q[63:32];
            div_val = div_ovf ? ismd_pkg::SAT_UNSIGNED : dvd_q[31:0];
        end else if (neg_q) begin
            div_ovf = dvd_q > {32'h0, ismd_pkg::SAT_NEG};
            div_val = div_ovf ? ismd_pkg::SAT_NEG : 32'h0 - dvd_q[31:0];
        end else begin
            div_ovf = dvd_q > {32'h0, ismd_pkg::SAT_POS};
            div_val = div_ovf ? ismd_pkg::SAT_POS : dvd_q[31:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ismd_pkg::DS_IDLE;
            cnt_q <= '0;
            dvd_q <= '0;
            rem_q <= '0;
            dvs_q <= '0;
            neg_q <= 1'b0;
            signed_q <= 1'b0;
            div_cc_q <= 1'b0;
        end else begin
            unique case (state_q)
                ismd_pkg::DS_IDLE: begin
                    if (launch && div_go) begin
                        signed_q <= op == ismd_pkg::OP_SQUOT
                            || op == ismd_pkg::OP_SQUOT_CC;
                        div_cc_q <= op == ismd_pkg::OP_UQUOT_CC
                            || op == ismd_pkg::OP_SQUOT_CC;
                        neg_q <= (op == ismd_pkg::OP_SQUOT
                            || op == ismd_pkg::OP_SQUOT_CC)
                            && (ext_q[31] ^ opnd_b[31]);
                        dvs_q <= ((op == ismd_pkg::OP_SQUOT
                            || op == ismd_pkg::OP_SQUOT_CC) && opnd_b[31])
                            ? 32'h0 - opnd_b : opnd_b;
                        dvd_q <= dvd_mag;
                        rem_q <= '0;
                        cnt_q <= '0;
                        state_q <= ismd_pkg::DS_STEP;
                    end
                end
                ismd_pkg::DS_STEP: begin
                    rem_q <= div_ge ? div_shift - {1'b0, dvs_q} : div_shift;
                    dvd_q <= {dvd_q[62:0], div_ge};
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == ismd_pkg::DIV_LAST) begin
                        state_q <= ismd_pkg::DS_END;
                    end
                end
                ismd_pkg::DS_END: state_q <= ismd_pkg::DS_IDLE;
                default: state_q <= ismd_pkg::DS_IDLE;
            endcase
        end
    end

    // =========================================================
    // result, extension and flags: divide end, engine, then bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_q <= '0;
            ext_q <= '0;
            flags_q <= '0;
        end else if (state_q == ismd_pkg::DS_END) begin
            result_q <= div_val;
            if (div_cc_q)
                flags_q <= {div_val[31], div_val == 32'h0, div_ovf,
                    1'b0};
        end else if (launch) begin
            if (res_we)
                result_q <= res_val;
            if (ext_we)
                ext_q <= ext_val;
            if (flg_we)
                flags_q <= flg_val;
        end else if (bus_wr) begin
            if (wr_addr_q == ismd_pkg::OFF_EXT)
                ext_q <= hwdata;
            if (wr_addr_q == ismd_pkg::OFF_FLAGS)
                flags_q <= hwdata[ismd_pkg::FLG_W-1:0];
        end
    end

    // =========================================================
    // completion status; a launch clears and sets in one step, so a
    // new trap is never lost to the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trap_tag_q <= 1'b0;
            trap_dz_q <= 1'b0;
            dovf_q <= 1'b0;
            done_q <= 1'b0;
            op_done_q <= 1'b0;
        end else begin
            op_done_q <= (launch && !div_go)
                || state_q == ismd_pkg::DS_END;
            if (launch) begin
                trap_tag_q <= tag_trap;
                trap_dz_q <= dz_trap;
                dovf_q <= 1'b0;
                done_q <= !div_go;
            end else if (state_q == ismd_pkg::DS_END) begin
                dovf_q <= div_ovf;
                done_q <= 1'b1;
            end
        end
    end
    assign trap_tag = trap_tag_q;
    assign trap_div_zero = trap_dz_q;
    assign op_done = op_done_q;
    // =========================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_diff_value: assert property (
        launch && op == ismd_pkg::OP_DIFF
        |=> result_q == $past(src_a_q - opnd_b))
        else $error("plain difference wrong");
    a_borrow_value: assert property (
        launch && op == ismd_pkg::OP_BORROW
        |=> result_q == $past(src_a_q - opnd_b
            - {31'h0, flags_q[ismd_pkg::FLG_C]}))
        else $error("borrow difference wrong");
    a_sub_overflow: assert property (
        launch && op == ismd_pkg::OP_DIFF_CC
        |=> flags_q[ismd_pkg::FLG_V] == ($past(src_a_q[31] != opnd_b[31])
            && result_q[31] != $past(src_a_q[31])))
        else $error("subtract overflow flag wrong");
    a_tag_trap_hold: assert property (
        launch && op == ismd_pkg::OP_TAG_TRAP && (|src_a_q[1:0])
        |=> trap_tag && $stable(result_q) && $stable(flags_q))
        else $error("tag trap did not hold state");
    a_tag_flag_v: assert property (
        launch && op == ismd_pkg::OP_TAG_CC && (|opnd_b[1:0])
        |=> flags_q[ismd_pkg::FLG_V] && !trap_tag)
        else $error("tag flag not set");
    a_step_ext: assert property (
        launch && op == ismd_pkg::OP_MUL_STEP
        |=> ext_q == {$past(src_a_q[0]), $past(ext_q[31:1])})
        else $error("step extension shift wrong");
    a_prod_split: assert property (
        launch && op == ismd_pkg::OP_UPROD
        |=> {ext_q, result_q} == $past(uprod))
        else $error("product split wrong");
    a_div_zero: assert property (
        launch && dz_trap
        |=> trap_div_zero && $stable(result_q) && !busy)
        else $error("zero divisor not trapped");
    a_div_latency: assert property (
        launch && div_go |-> ##66 op_done)
        else $error("divide did not finish in time");
    a_udiv_sat: assert property (
        state_q == ismd_pkg::DS_END && !signed_q && (|dvd_q[63:32])
        |=> result_q == ismd_pkg::SAT_UNSIGNED)
        else $error("unsigned saturation wrong");
    c_tag_trap: cover property (launch && tag_trap);
    c_div_done: cover property (state_q == ismd_pkg::DS_END && signed_q);
    c_div_ovf: cover property (state_q == ismd_pkg::DS_END && div_ovf);
    c_step: cover property (launch && op == ismd_pkg::OP_MUL_STEP);
endmodule

`default_nettype wire

//--- bench/ismd_bus_master.sv
// register bus master standing in for the integer pipeline
`timescale 1ns/1ns
`default_nettype none

module ismd_bus_master (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // =========================================================
    // idle bus from time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = ismd_pkg::HSIZE_WORD;
        hwdata = 32'h0;
    end

    // waits for hready at a rising edge, bounded
    task automatic rdy(inout logic t);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        t = t | (n >= 50);
    endtask

    // =========================================================
    // one single word transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic t);
        t = 1'b0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        rdy(t);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy(t);
        q = hrdata;
        // released data lines must not keep showing the old word
        hwdata <= ~d;
    endtask
endmodule
`default_nettype wire

//--- bench/test_integer_sub_mul_div_unit.sv
// self-checking bench for the subtract, multiply and divide unit
`timescale 1ns/1ns
`default_nettype none

module test_integer_sub_mul_div_unit;
    logic hclk, hresetn, hsel, hwrite, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic trap_tag, trap_div_zero, op_done;
    int err_count, checks_done;
    logic hready_o;

    // single slave, so its ready is the bus ready
    assign hready = hready_o;

    ismd_unit u_ismd_unit (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hready_o), .hresp(hresp), .trap_tag(trap_tag),
        .trap_div_zero(trap_div_zero), .op_done(op_done));

    ismd_bus_master u_ismd_bus_master (.hclk(hclk), .hready(hready),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // =========================================================
    // reporting
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input string s, input logic [31:0] x,
                       input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", s, x, g);
        end
    endtask

    // a bus transfer that hangs ends the run as a mismatch
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        logic t;
        u_ismd_bus_master.xfer(w, a, d, q, t);
        if (t) begin
            err_count++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    // =========================================================
    // load operands, launch, wait for done, check traps, result, extension and flags
    task automatic run(input logic [4:0] c, input logic [31:0] a, b, e,
                       input logic [3:0] f, input logic [31:0] xr, xe,
                       input logic [3:0] xf, input logic [1:0] xt);
        logic [31:0] q;
        int n;
        wr(ismd_pkg::OFF_SRC_A, a);
        wr(ismd_pkg::OFF_SRC_B, b);
        wr(ismd_pkg::OFF_EXT, e);
        wr(ismd_pkg::OFF_FLAGS, {28'h0, f});
        wr(ismd_pkg::OFF_CMD, {27'h0, c});
        n = 0;
        #1;
        while (op_done !== 1'b1 && n < 200) begin
            @(posedge hclk);
            #1;
            n++;
        end
        if (n >= 200) begin
            err_count++;
            end_of_test();
        end
        cmp("traps", {30'h0, xt}, {30'h0, trap_div_zero, trap_tag});
        @(posedge hclk);
        bus(1'b0, ismd_pkg::OFF_RESULT, 32'h0, q);
        cmp("result", xr, q);
        bus(1'b0, ismd_pkg::OFF_EXT, 32'h0, q);
        cmp("extension", xe, q);
        bus(1'b0, ismd_pkg::OFF_FLAGS, 32'h0, q);
        cmp("flags", {28'h0, xf}, q);
    endtask

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // =========================================================
    // main sequence; immediate held at minus one throughout
    initial begin
        logic [31:0] q;
        err_count = 0;
        checks_done = 0;
        hresetn = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        wr(ismd_pkg::OFF_IMM, 32'h1FFF);
        run(ismd_pkg::OP_DIFF, 32'h5, 32'h7, 32'h0, 4'h5,
            32'hFFFFFFFE, 32'h0, 4'h5, 2'h0);
        run({1'b1, ismd_pkg::OP_DIFF_CC}, 32'h80000000, 32'h0, 32'h0, 4'h0,
            32'h80000001, 32'h0, 4'h9, 2'h0);
        run(ismd_pkg::OP_DIFF_CC, 32'h7FFFFFFF, 32'hFFFFFFFF, 32'h0, 4'h0,
            32'h80000000, 32'h0, 4'hB, 2'h0);
        run(ismd_pkg::OP_DIFF_CC, 32'h20, 32'h20, 32'h0, 4'hF,
            32'h0, 32'h0, 4'h4, 2'h0);
        run(ismd_pkg::OP_BORROW, 32'h10, 32'h3, 32'h0, 4'h1,
            32'hC, 32'h0, 4'h1, 2'h0);
        run(ismd_pkg::OP_BORROW_CC, 32'h10, 32'h10, 32'h0, 4'h1,
            32'hFFFFFFFF, 32'h0, 4'h9, 2'h0);
        run(ismd_pkg::OP_TAG_CC, 32'h8, 32'h4, 32'h0, 4'hF,
            32'h4, 32'h0, 4'h0, 2'h0);
        run(ismd_pkg::OP_TAG_CC, 32'h8, 32'h6, 32'h0, 4'h0,
            32'h2, 32'h0, 4'h2, 2'h0);
        run(ismd_pkg::OP_TAG_TRAP, 32'h9, 32'h4, 32'h0, 4'h4,
            32'h2, 32'h0, 4'h4, 2'h1);
        run(ismd_pkg::OP_TAG_TRAP, 32'h7FFFFFFC, 32'hFFFFFFFC, 32'h0, 4'h0,
            32'h2, 32'h0, 4'h0, 2'h1);
        run(ismd_pkg::OP_TAG_TRAP, 32'hC, 32'h8, 32'h0, 4'h2,
            32'h4, 32'h0, 4'h0, 2'h0);
        run(ismd_pkg::OP_MUL_STEP, 32'h5, 32'h3, 32'h1, 4'h8,
            32'h80000005, 32'h80000000, 4'h8, 2'h0);
        run(ismd_pkg::OP_MUL_STEP, 32'h4, 32'h3, 32'h2, 4'h2,
            32'h80000002, 32'h1, 4'h8, 2'h0);
        run(ismd_pkg::OP_UPROD, 32'hFFFFFFFF, 32'h2, 32'h0, 4'h5,
            32'hFFFFFFFE, 32'h1, 4'h5, 2'h0);
        run(ismd_pkg::OP_SPROD, 32'hFFFFFFFF, 32'h2, 32'h0, 4'h5,
            32'hFFFFFFFE, 32'hFFFFFFFF, 4'h5, 2'h0);
        run(ismd_pkg::OP_UPROD_CC, 32'h10000, 32'h10000, 32'h0, 4'h3,
            32'h0, 32'h1, 4'h4, 2'h0);
        run(ismd_pkg::OP_SPROD_CC, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 4'hF,
            32'h1, 32'h0, 4'h0, 2'h0);
        run(ismd_pkg::OP_UQUOT, 32'h7, 32'h2, 32'h0, 4'hF,
            32'h3, 32'h0, 4'hF, 2'h0);
        run(ismd_pkg::OP_UQUOT, 32'h0, 32'h0, 32'h0, 4'h5,
            32'h3, 32'h0, 4'h5, 2'h2);
        run(ismd_pkg::OP_UQUOT_CC, 32'h0, 32'h1, 32'h1, 4'h1,
            32'hFFFFFFFF, 32'h1, 4'hA, 2'h0);
        run(ismd_pkg::OP_SQUOT, 32'hFFFFFFFD, 32'h2, 32'hFFFFFFFF, 4'h0,
            32'hFFFFFFFF, 32'hFFFFFFFF, 4'h0, 2'h0);
        run(ismd_pkg::OP_SQUOT_CC, 32'h0, 32'h1, 32'h1, 4'h1,
            32'h7FFFFFFF, 32'h1, 4'h2, 2'h0);
        run(ismd_pkg::OP_SQUOT_CC, 32'h0, 32'h1, 32'hFFFFFFFF, 4'h0,
            32'h80000000, 32'hFFFFFFFF, 4'hA, 2'h0);
        run({1'b1, ismd_pkg::OP_SQUOT_CC}, 32'h6, 32'h0, 32'h0, 4'h0,
            32'hFFFFFFFA, 32'h0, 4'h8, 2'h0);
        run(ismd_pkg::OP_UQUOT, 32'h0, 32'h1, 32'h1, 4'h5,
            32'hFFFFFFFF, 32'h1, 4'h5, 2'h0);
        // non-flag overflow still shows in status: done and overflow set
        bus(1'b0, ismd_pkg::OFF_STATUS, 32'h0, q);
        cmp("status", 32'h12, q);
        // unmapped read after busy traffic, so stale read data would show
        bus(1'b0, 8'hFC, 32'h0, q);
        cmp("unmapped", 32'h0, q);
        cmp("response", {31'h0, ismd_pkg::HRESP_OKAY}, {31'h0, hresp});
        end_of_test();
    end
endmodule
`default_nettype wire
